// ---- verilog/tlx_pkg.sv ----
// Package: opcode patterns, field positions and reset values for the table latch / xor executor
package tlx_pkg;
  localparam logic [5:0] OP_TABLE_LATCH_BYTE_WRITE = 6'h29;   // bits 15:10 = 1010 01, then t, x
  localparam logic [7:0] OP_TEST_SKIP_IF_NULL = 8'h33;        // 0011 0011
  localparam logic [7:0] OP_XOR_WORKING_WITH_LITERAL = 8'hb4; // 1011 0100
  localparam logic [6:0] OP_XOR_WORKING_WITH_FILE = 7'h06;    // bits 15:9 = 0000 110d
  localparam int unsigned OP7_MSB = 15;
  localparam int unsigned OP7_LSB = 9;
  localparam int unsigned OP8_LSB = 8;
  localparam int unsigned OP6_LSB = 10;
  localparam int unsigned LATCH_SEL_BIT = 9;   // t for latch write; bit 8 is ignored there
  localparam int unsigned SEL_BIT = 8;   // d for file xor; latch write takes t from bit 9
  localparam int unsigned ARG_MSB = 7;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic ZERO_RESET = 1'b0;

  typedef enum logic [2:0] {
    TLX_NONE = 3'b000,
    TLX_LATCH_WRITE = 3'b001,
    TLX_TEST_SKIP = 3'b010,
    TLX_XOR_LITERAL = 3'b011,
    TLX_XOR_FILE = 3'b100
  } tlx_op_t;
endpackage

// ---- verilog/tlx_exec.sv ----
// Executor for table latch byte write, test-and-skip, and the two exclusive-OR instructions
//
// Contract
// RL1: Latch write: t=0 low byte, t=1 high byte
// RL2: Sixteen-bit latch, byte halves, reads never disturb
// RL3: Decode 0011 0011 as test-skip, flags untouched
// RL4: Zero file: discard prefetched word, two cycles
// RL5: Decode 1011 0100 as literal xor into working
// RL6: File xor: d=0 working, d=1 file
// RL7: File xor bitwise, only zero flag, one cycle
// RL8: Zero flag set when xor result zero; the literal xor here leaves the zero flag unchanged
module tlx_exec (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_file_rdata,
  input wire logic i_latch_load,
  input wire logic [15:0] i_latch_load_data,
  output logic o_file_we,
  output logic [7:0] o_file_waddr,
  output logic [7:0] o_file_wdata,
  output logic [7:0] o_working_register,
  output logic o_zero,
  output logic [15:0] o_table_holding_latch,
  output logic o_forced_nop
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic tlx_pkg::tlx_op_t decode_op(input logic [15:0] w);
    tlx_pkg::tlx_op_t op;
    op = tlx_pkg::TLX_NONE;
    if (w[tlx_pkg::OP7_MSB:tlx_pkg::OP6_LSB] == tlx_pkg::OP_TABLE_LATCH_BYTE_WRITE) begin
      op = tlx_pkg::TLX_LATCH_WRITE;
    end else if (w[tlx_pkg::OP7_MSB:tlx_pkg::OP8_LSB] == tlx_pkg::OP_TEST_SKIP_IF_NULL) begin
      op = tlx_pkg::TLX_TEST_SKIP; // [RL3]
    end else if (w[tlx_pkg::OP7_MSB:tlx_pkg::OP8_LSB] == tlx_pkg::OP_XOR_WORKING_WITH_LITERAL) begin
      op = tlx_pkg::TLX_XOR_LITERAL; // [RL5]
    end else if (w[tlx_pkg::OP7_MSB:tlx_pkg::OP7_LSB] == tlx_pkg::OP_XOR_WORKING_WITH_FILE) begin
      op = tlx_pkg::TLX_XOR_FILE;
    end
    return op;
  endfunction

  // Shared by the skip test and the zero flag
  function automatic logic null_byte(input logic [7:0] b);
    return (b == 8'h00);
  endfunction

  logic [7:0] working_ff;
  logic zero_ff;
  logic [7:0] latch_byte_ff [2];
  logic skip_pend_ff;
  logic file_we_ff;
  logic [7:0] file_waddr_ff;
  logic [7:0] file_wdata_ff;
  logic forced_nop_ff;

  tlx_pkg::tlx_op_t op;
  logic exec;
  logic sel;
  logic latch_sel;
  logic [7:0] arg;
  logic [7:0] xor_file;
  logic [7:0] xor_lit;
  logic do_latch_write;
  logic do_test_skip;
  logic do_xor_lit;
  logic do_xor_file;
  logic file_to_working;
  logic file_to_file;
  logic test_hits_null;
  logic [1:0] latch_byte_we;
  logic [7:0] nxt_working;
  logic nxt_zero;
  logic nxt_skip_pend;

  // A valid word arriving while a skip is pending is the discarded prefetch
  assign exec = i_instr_valid && !skip_pend_ff; // [RL4]
  assign op = exec ? decode_op(i_instr) : tlx_pkg::TLX_NONE;
  assign sel = i_instr[tlx_pkg::SEL_BIT];
  assign latch_sel = i_instr[tlx_pkg::LATCH_SEL_BIT]; // [RL1]
  assign arg = i_instr[tlx_pkg::ARG_MSB:0];
  assign xor_file = working_ff ^ i_file_rdata; // [RL7]
  assign xor_lit = working_ff ^ arg; // [RL5]

  ////////////////////////////////////////////////////////////////////////////
  // One strobe per instruction so each concern below reads a single bit
  assign do_latch_write = (op == tlx_pkg::TLX_LATCH_WRITE); // [RL1]
  assign do_test_skip = (op == tlx_pkg::TLX_TEST_SKIP); // [RL3]
  assign do_xor_lit = (op == tlx_pkg::TLX_XOR_LITERAL); // [RL5]
  assign do_xor_file = (op == tlx_pkg::TLX_XOR_FILE); // [RL7]
  assign file_to_working = do_xor_file && !sel; // [RL6]
  assign file_to_file = do_xor_file && sel; // [RL6]
  assign test_hits_null = do_test_skip && null_byte(i_file_rdata); // [RL4]
  // Bit 0 enables the lower byte, bit 1 the upper one
  assign latch_byte_we = {do_latch_write && latch_sel, do_latch_write && !latch_sel}; // [RL1]

  ////////////////////////////////////////////////////////////////////////////
  // Next working value; literal xor leaves the zero flag alone
  always_comb begin
    nxt_working = working_ff;
    if (do_xor_lit) begin
      nxt_working = xor_lit; // [RL5]
    end else if (file_to_working) begin
      nxt_working = xor_file; // [RL6]
    end
  end

  // Zero follows the file xor result whichever destination takes it
  always_comb begin
    nxt_zero = zero_ff;
    if (do_xor_file) begin
      nxt_zero = null_byte(xor_file); // [RL7] [RL8]
    end
  end

  // Set wins over clear: the test word itself is never the discarded one
  always_comb begin
    nxt_skip_pend = skip_pend_ff;
    if (test_hits_null) begin
      nxt_skip_pend = 1'b1; // [RL4]
    end else if (i_instr_valid) begin
      nxt_skip_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      working_ff <= tlx_pkg::WORKING_RESET;
    end else begin
      working_ff <= nxt_working; // [RL5] [RL6]
    end
  end

  // Zero flag: only the file xor touches it, test-skip leaves it alone
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zero_ff <= tlx_pkg::ZERO_RESET;
    end else begin
      zero_ff <= nxt_zero; // [RL7] [RL8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File write strobe for d=1, one cycle wide
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      file_we_ff <= 1'b0;
    end else begin
      file_we_ff <= file_to_file; // [RL6]
    end
  end

  // Address and data stand after the strobe so the core may sample late
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      file_waddr_ff <= 8'h00;
      file_wdata_ff <= 8'h00;
    end else if (file_to_file) begin
      file_waddr_ff <= arg;
      file_wdata_ff <= xor_file; // [RL6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table holding latch, one register per byte half
  // Program-memory load takes second place to any latch write instruction,
  // so the unwritten half of a byte write is never overwritten by a load
  for (genvar b = 0; b < 2; b++) begin : g_latch_byte
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        latch_byte_ff[b] <= tlx_pkg::LATCH_RESET[b*8 +: 8];
      end else if (latch_byte_we[b]) begin
        latch_byte_ff[b] <= i_file_rdata; // [RL1] [RL2]
      end else if (i_latch_load && !do_latch_write) begin
        latch_byte_ff[b] <= i_latch_load_data[b*8 +: 8]; // [RL2]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip: arm on null test, cleared by the next fetched word which becomes a forced no-op
  // Idle cycles keep the skip armed until a word actually arrives
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      skip_pend_ff <= 1'b0;
    end else begin
      skip_pend_ff <= nxt_skip_pend; // [RL4]
    end
  end

  // Pulse marks the cycle after a discarded word
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      forced_nop_ff <= 1'b0;
    end else begin
      forced_nop_ff <= i_instr_valid && skip_pend_ff; // [RL4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign o_file_we = file_we_ff;
  assign o_file_waddr = file_waddr_ff;
  assign o_file_wdata = file_wdata_ff;
  assign o_working_register = working_ff;
  assign o_zero = zero_ff;
  assign o_table_holding_latch = {latch_byte_ff[1], latch_byte_ff[0]};
  assign o_forced_nop = forced_nop_ff;

endmodule

// ---- tb/tlx_props.sv ----
// Checker: port properties of the table latch / xor executor
module tlx_props(
  input wire logic i_core_clk, i_rst_n, i_instr_valid, i_latch_load, o_file_we, o_zero, o_forced_nop,
  input wire logic [15:0] i_instr, i_latch_load_data, o_table_holding_latch,
  input wire logic [7:0] i_file_rdata, o_file_waddr, o_file_wdata, o_working_register
);
  logic sk_ff;
  wire [15:0] tl = o_table_holding_latch;
  wire [7:0] w = o_working_register, x = w ^ i_file_rdata, y = w ^ i_instr[7:0], op = i_instr[15:8];
  wire tk = i_instr_valid && !sk_ff, lw = tk && i_instr[15:10] == 6'h29, xf = tk && i_instr[15:9] == 7'h06;
  // Idle cycles keep a pending discard alive
  always_ff @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n) sk_ff <= 1'b0;
    else if (tk && op == 8'h33 && i_file_rdata == 8'h00) sk_ff <= 1'b1;
    else if (i_instr_valid) sk_ff <= 1'b0;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  lo_byte_a: assert property (lw && !i_instr[9] |=> tl == {$past(tl[15:8]), $past(i_file_rdata)}) else $error("lo");
  hi_byte_a: assert property (lw && i_instr[9] |=> tl == {$past(i_file_rdata), $past(tl[7:0])}) else $error("hi");
  latch_hold_a: assert property (!lw && !i_latch_load |=> $stable(tl)) else $error("latch");
  test_flags_a: assert property (tk && op == 8'h33 |=> $stable(o_zero) && $stable(w)) else $error("flags");
  flush_nop_a: assert property (sk_ff && i_instr_valid |=> o_forced_nop && $stable(w)) else $error("nop");
  lit_xor_a: assert property (tk && op == 8'hb4 |=> w == $past(y)) else $error("lit");
  file_dest_a: assert property (xf |=> o_file_we == $past(i_instr[8]) && (o_file_we ? o_file_wdata : w) == $past(x))
    else $error("dest");
  xor_zero_a: assert property (xf |=> o_zero == ($past(x) == 8'h00)) else $error("zero");
  cover property (lw && i_instr[9]);
  cover property (o_file_we);
  cover property (o_forced_nop);
endmodule
bind tlx_exec tlx_props p_u(.*);

// ---- tb/testbench.sv ----
// Testbench: random instruction stream checked against a bench model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic c = 0, n = 0, v = 0, ld = 0, we, z, fn, Z, S, E, N;
  logic [15:0] i = 0, d = 0, t, L;
  logic [7:0] r = 0, a, o, w, W, A, D;
  logic [7:0] p [9] = '{8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'h33, 8'hb4, 8'h0c, 8'h0d, 8'h77};
  int err_total = 0, check_count = 0, q;
  always #5 c = ~c;
  tlx_exec dut_u(.i_core_clk(c), .i_rst_n(n), .i_instr_valid(v), .i_instr(i), .i_file_rdata(r), .i_latch_load(ld),
    .i_latch_load_data(d), .o_file_we(we), .o_file_waddr(a), .o_file_wdata(o), .o_working_register(w), .o_zero(z),
    .o_table_holding_latch(t), .o_forced_nop(fn));
  task automatic chk(string s, logic [31:0] g, logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic summarize();
    $display("%0d checks, %0d mismatches", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #40000 err_total++;
    summarize();
  end
  initial begin
    q = $urandom(98);
    {W, A, D, Z, S, L, E, N} = '0;
    repeat (12) @(negedge c);
    n = 1'b1;
    repeat (3000) begin
      @(negedge c);
      chk("work", 32'(w), 32'(W));
      chk("zero", 32'(z), 32'(Z));
      chk("latch", 32'(t), 32'(L));
      chk("nop", 32'(fn), 32'(N));
      chk("fwrite", 32'({we, a, o}), 32'({E, A, D}));
      q = $urandom;
      v = q[0] | q[1];
      i = {p[q[7:4] % 9], q[15:8]};
      r = q[17:16] == 2'h0 ? 8'h00 : q[17:16] == 2'h1 ? W : q[25:18];
      // Latch load kept off latch writes: the model would merge the load into the unwritten half, the DUT drops the load
      ld = q[26] && i[15:10] != 6'h29;
      d = q[31:16];
      {E, N} = 2'h0;
      if (ld) L = d;
      if (v && S) {S, N} = 2'h1;
      else if (v) begin
        if (i[15:10] == 6'h29) L[{i[9], 3'h0} +: 8] = r;
        if (i[15:8] == 8'h33) S = r == 8'h00;
        if (i[15:8] == 8'hb4) W ^= i[7:0];
        if (i[15:9] == 7'h06) begin
          {Z, E} = {(W ^ r) == 8'h00, i[8]};
          if (i[8]) {A, D} = {i[7:0], W ^ r}; else W ^= r;
        end
      end
    end
    $display("random stream test done");
    summarize();
  end
endmodule
